// *** rtl/pll_cfg_pkg.sv ***
// Register map, field layout and reset values of the synthesizer
// feedback configuration bank.
// Assumes a 32-bit APB slave with one aligned word per register.
package pll_cfg_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  typedef logic [7:0] byte_t;

  localparam int    NUM_REGS              = 10;
  localparam byte_t IDX_INT_DIVIDER_HIGH  = 8'h3A;
  localparam byte_t IDX_INT_DIVIDER_LOW   = 8'h3B;
  localparam byte_t IDX_FRAC_NUM_HIGH     = 8'h3C;
  localparam byte_t IDX_FRAC_NUM_MID      = 8'h3D;
  localparam byte_t IDX_FRAC_NUM_LOW      = 8'h3E;
  localparam byte_t IDX_FRAC_DEN_HIGH     = 8'h3F;
  localparam byte_t IDX_FRAC_DEN_MID      = 8'h40;
  localparam byte_t IDX_FRAC_DEN_LOW      = 8'h41;
  localparam byte_t IDX_MODULATOR_CONTROL = 8'h42;
  localparam byte_t IDX_LOOP_RESISTOR     = 8'h43;
  localparam int    BYTE_ADDR_SHIFT       = 2;

  // Storage slots, in index order
  localparam int SLOT_INT_HIGH = 0;
  localparam int SLOT_INT_LOW  = 1;
  localparam int SLOT_NUM_HIGH = 2;
  localparam int SLOT_NUM_MID  = 3;
  localparam int SLOT_NUM_LOW  = 4;
  localparam int SLOT_DEN_HIGH = 5;
  localparam int SLOT_DEN_MID  = 6;
  localparam int SLOT_DEN_LOW  = 7;
  localparam int SLOT_MODCTL   = 8;
  localparam int SLOT_LOOP_RES = 9;

  localparam byte_t REG_INDEX [NUM_REGS] = '{
    IDX_INT_DIVIDER_HIGH, IDX_INT_DIVIDER_LOW, IDX_FRAC_NUM_HIGH,
    IDX_FRAC_NUM_MID, IDX_FRAC_NUM_LOW, IDX_FRAC_DEN_HIGH,
    IDX_FRAC_DEN_MID, IDX_FRAC_DEN_LOW, IDX_MODULATOR_CONTROL,
    IDX_LOOP_RESISTOR};

  // ----------------------------------------------------------------
  // Writable bits and reset values
  // ----------------------------------------------------------------
  localparam byte_t WRITE_MASK [NUM_REGS] = '{
    8'h0F, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'h0F, 8'h3F};
  localparam byte_t RESET_VAL [NUM_REGS] = '{
    8'h00, 8'h66, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0C, 8'h24};

  // ----------------------------------------------------------------
  // Fields and widths
  // ----------------------------------------------------------------
  localparam int INT_DIV_W   = 12;
  localparam int FRAC_W      = 22;
  localparam int RES_CODE_W  = 6;
  localparam int DITHER_LSB  = 2;
  localparam int ORDER_LSB   = 0;
  localparam logic [11:0] MIN_RATIO = 12'h001;

  typedef enum logic [1:0] {
    DITHER_WEAK     = 2'h0,
    DITHER_MEDIUM   = 2'h1,
    DITHER_STRONG   = 2'h2,
    DITHER_DISABLED = 2'h3
  } dither_mode_e;

  typedef enum logic [1:0] {
    ORDER_INTEGER = 2'h0,
    ORDER_FIRST   = 2'h1,
    ORDER_SECOND  = 2'h2,
    ORDER_THIRD   = 2'h3
  } mash_order_e;

endpackage

// *** rtl/pll_frac_divider_config_regs.sv ***
// APB register bank that holds the feedback divider, fraction and
// modulator settings of the first synthesizer.
// Assumes an APB master on pclk; all synthesizer config outputs are static levels.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

// Contract
// - The integer divider is 12 bits, nibble from the high register.
// - Divider codes zero and one divide by one, others by the code.
// - After reset the divider high nibble is zero and low byte 0x66.
// - The 22-bit numerator is built from three bytes, all reset zero.
// - The 22-bit denominator is built the same way, all reset zero.
// - Dither select at bits 3:2 resets to dither disabled.
// - Modulator order at bits 1:0 resets to integer mode.
// - The six-bit loop resistor code resets to 0x24.
module pll_frac_divider_config_regs
  import pll_cfg_pkg::*;
#(
  parameter int PADDR_W = 12
) (
  // Clock and reset
  input  logic                             pclk,
  input  logic                             presetn,
  // APB slave
  input  logic                             psel,
  input  logic                             penable,
  input  logic                             pwrite,
  input  logic [PADDR_W-1:0]               paddr,
  input  logic [31:0]                      pwdata,
  input  logic [3:0]                       pstrb,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Synthesizer configuration
  output logic [pll_cfg_pkg::INT_DIV_W-1:0] integer_feedback_divider,
  output logic [pll_cfg_pkg::INT_DIV_W-1:0] divide_ratio,
  output logic [pll_cfg_pkg::FRAC_W-1:0]    fraction_numerator,
  output logic [pll_cfg_pkg::FRAC_W-1:0]    fraction_denominator,
  output pll_cfg_pkg::dither_mode_e         dither_select,
  output pll_cfg_pkg::mash_order_e          modulator_order,
  output logic [pll_cfg_pkg::RES_CODE_W-1:0] loop_resistor_code
);

  import pll_cfg_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // Highest byte address is 0x10C, so nine address bits are needed
  if (PADDR_W < 9 || PADDR_W > 32) begin : g_bad_width
    $error("PADDR_W must lie between 9 and 32");
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  localparam logic [3:0] NO_SLOT = 4'hF;

  // Maps a byte address to a storage slot, NO_SLOT when unmapped
  // A linear search keeps the map in one table; ten compares are cheap
  function automatic logic [3:0] decode_slot(
    input logic [PADDR_W-1:0] addr
  );
    logic [3:0] slot;
    slot = NO_SLOT;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (addr == PADDR_W'({REG_INDEX[i], 2'h0})) begin
        slot = 4'(i);
      end
    end
    return slot;
  endfunction

  logic [7:0]  cfg_ff [NUM_REGS];
  logic [3:0]  acc_slot;
  logic        setup_phase;
  logic        wr_en;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;
  logic [INT_DIV_W-1:0] ratio_ff;
  logic [INT_DIV_W-1:0] nxt_ratio;
  logic [INT_DIV_W-1:0] int_code;

  assign acc_slot    = decode_slot(paddr);
  assign setup_phase = psel && !penable;
  // A write lands only at the completing edge of a good access
  assign wr_en = psel && penable && pready_ff && pwrite
                 && !pslverr_ff && pstrb[0];

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  // Ready is raised for the access phase that follows each setup,
  // so every transfer finishes with no wait state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= setup_phase;
    end
  end

  // Unmapped or unaligned addresses answer with an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= setup_phase && (acc_slot == NO_SLOT);
    end
  end

  // Captured at setup so the word stands through the access cycle
  // read zero fill
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup_phase && !pwrite && acc_slot != NO_SLOT) begin
      prdata_ff <= {24'h00_0000, cfg_ff[acc_slot]};
    end else if (setup_phase) begin
      prdata_ff <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  // reset values and write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        cfg_ff[i] <= RESET_VAL[i];
      end
    end else if (wr_en && acc_slot != NO_SLOT) begin
      cfg_ff[acc_slot] <= pwdata[7:0] & WRITE_MASK[acc_slot];
    end
  end

  // ----------------------------------------------------------------
  // Divide ratio
  // ----------------------------------------------------------------
  // integer divider assembly
  assign int_code = {cfg_ff[SLOT_INT_HIGH][3:0], cfg_ff[SLOT_INT_LOW]};

  always_comb begin
    nxt_ratio = int_code;
    if (int_code < 12'h002) begin
      nxt_ratio = MIN_RATIO;
    end
  end

  // Registered so the output comes from a flop; lags by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ratio_ff <= {RESET_VAL[SLOT_INT_HIGH][3:0], RESET_VAL[SLOT_INT_LOW]};
    end else begin
      ratio_ff <= nxt_ratio;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign divide_ratio = ratio_ff;
  assign integer_feedback_divider = int_code;
  assign fraction_numerator = {cfg_ff[SLOT_NUM_HIGH][5:0],
                               cfg_ff[SLOT_NUM_MID], cfg_ff[SLOT_NUM_LOW]};
  assign fraction_denominator = {cfg_ff[SLOT_DEN_HIGH][5:0],
                                 cfg_ff[SLOT_DEN_MID], cfg_ff[SLOT_DEN_LOW]};
  assign dither_select =
    dither_mode_e'(cfg_ff[SLOT_MODCTL][DITHER_LSB +: 2]);
  assign modulator_order =
    mash_order_e'(cfg_ff[SLOT_MODCTL][ORDER_LSB +: 2]);
  assign loop_resistor_code = cfg_ff[SLOT_LOOP_RES][RES_CODE_W-1:0];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic first_ff;

  // High only on the first edge after reset is released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_ff <= 1'b1;
    end else begin
      first_ff <= 1'b0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence wr_to(int s);
    wr_en && (acc_slot == 4'(s));
  endsequence

  sequence rd_to(int s);
    setup_phase && !pwrite && (acc_slot == 4'(s));
  endsequence

  int_high_write_a : assert property (
    wr_to(SLOT_INT_HIGH) |=>
      integer_feedback_divider[11:8] == $past(pwdata[3:0]))
    else $error("divider high nibble not taken from write");

  ratio_floor_a : assert property (
    ##1 (divide_ratio == (($past(int_code) < 12'h002) ?
                          12'h001 : $past(int_code))))
    else $error("divide ratio does not follow divider code");

  int_reset_a : assert property (
    first_ff |-> (integer_feedback_divider == 12'h066)
                 && (divide_ratio == 12'h066))
    else $error("divider not at default after reset");

  num_write_a : assert property (
    (first_ff |-> fraction_numerator == 22'h00_0000) and
    (wr_to(SLOT_NUM_HIGH) |=>
      fraction_numerator[21:16] == $past(pwdata[5:0])))
    else $error("numerator high bits wrong");

  den_write_a : assert property (
    (first_ff |-> fraction_denominator == 22'h00_0000) and
    (wr_to(SLOT_DEN_MID) |=>
      fraction_denominator[15:8] == $past(pwdata[7:0])))
    else $error("denominator middle byte wrong");

  dither_field_a : assert property (
    (first_ff |-> dither_select == DITHER_DISABLED) and
    (wr_to(SLOT_MODCTL) |=> dither_select == $past(pwdata[3:2])))
    else $error("dither select wrong");

  order_field_a : assert property (
    (first_ff |-> modulator_order == ORDER_INTEGER) and
    (wr_to(SLOT_MODCTL) |=> modulator_order == $past(pwdata[1:0])))
    else $error("modulator order wrong");

  resistor_code_a : assert property (
    (first_ff |-> loop_resistor_code == 6'h24) and
    (wr_to(SLOT_LOOP_RES) |=>
      loop_resistor_code == $past(pwdata[5:0])))
    else $error("loop resistor code wrong");

  reserved_read_a : assert property (
    rd_to(SLOT_INT_HIGH) ##1 (pready && !pslverr) |->
      prdata[31:4] == 28'h000_0000)
    else $error("reserved bits read nonzero");

  unmapped_err_a : assert property (
    setup_phase && (acc_slot == NO_SLOT) |=>
      pready && pslverr && (prdata == 32'h0000_0000))
    else $error("unmapped access not refused");

  // ----------------------------------------------------------------
  // Further checks
  // ----------------------------------------------------------------
  // High while every stored byte has its reserved bits clear
  logic reserved_clean;

  always_comb begin
    reserved_clean = 1'b1;
    for (int i = 0; i < NUM_REGS; i++) begin
      if ((cfg_ff[i] & ~WRITE_MASK[i]) != 8'h00) begin
        reserved_clean = 1'b0;
      end
    end
  end

  // A completing write that must not store: refused or strobe low
  sequence lost_wr;
    psel && penable && pready && pwrite && (pslverr || !pstrb[0]);
  endsequence

  // Setup of a read to any mapped register
  sequence rd_mapped;
    setup_phase && !pwrite && (acc_slot != NO_SLOT);
  endsequence

  int_low_write_a : assert property (
    wr_to(SLOT_INT_LOW) |=>
      integer_feedback_divider[7:0] == $past(pwdata[7:0]))
    else $error("divider low byte not taken from write");

  ratio_nonzero_a : assert property (
    divide_ratio != 12'h000)
    else $error("divide ratio fell to zero");

  num_low_bytes_a : assert property (
    (wr_to(SLOT_NUM_MID) |=>
      fraction_numerator[15:8] == $past(pwdata[7:0])) and
    (wr_to(SLOT_NUM_LOW) |=>
      fraction_numerator[7:0] == $past(pwdata[7:0])))
    else $error("numerator low bytes wrong");

  den_outer_bytes_a : assert property (
    (wr_to(SLOT_DEN_HIGH) |=>
      fraction_denominator[21:16] == $past(pwdata[5:0])) and
    (wr_to(SLOT_DEN_LOW) |=>
      fraction_denominator[7:0] == $past(pwdata[7:0])))
    else $error("denominator outer bytes wrong");

  resistor_read_a : assert property (
    rd_to(SLOT_LOOP_RES) |=>
      prdata == {26'h000_0000, $past(loop_resistor_code)})
    else $error("loop resistor code reads back wrong");

  read_fill_a : assert property (
    rd_mapped ##1 pready |-> !pslverr && (prdata[31:8] == 24'h00_0000))
    else $error("mapped read has error or nonzero upper bits");

  reserved_clear_a : assert property (
    reserved_clean)
    else $error("reserved register bits hold a one");

  config_hold_a : assert property (
    lost_wr |=> $stable(integer_feedback_divider)
      && $stable(fraction_numerator) && $stable(fraction_denominator)
      && $stable(dither_select) && $stable(modulator_order)
      && $stable(loop_resistor_code))
    else $error("refused write changed the configuration");

  // One access cycle per setup, never a stray ready
  pready_timing_a : assert property (
    (setup_phase |=> pready) and (!setup_phase |=> !pready))
    else $error("ready not exactly one cycle after setup");

  read_hold_a : assert property (
    !setup_phase |=> $stable(prdata))
    else $error("read data changed outside a setup cycle");

  mapped_no_err_a : assert property (
    setup_phase && (acc_slot != NO_SLOT) |=> !pslverr)
    else $error("mapped access answered with an error");

endmodule

// *** verification/pll_frac_divider_config_regs_test.sv ***
// Self-checking bench for the feedback configuration register bank.
// Assumes a zero-wait APB slave and a single 25 MHz clock.
`timescale 1ns/1ps
module pll_frac_divider_config_regs_test;
  import pll_cfg_pkg::*;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic         pclk;
  logic         presetn;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [11:0]  paddr;
  logic [31:0]  pwdata;
  logic [3:0]   pstrb;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [11:0]  int_div;
  logic [11:0]  ratio;
  logic [21:0]  num;
  logic [21:0]  den;
  dither_mode_e dither;
  mash_order_e  order;
  logic [5:0]   res_code;
  logic [31:0]  rdat;
  logic         rerr;
  int           bad_count;
  int           n_compared;
  int           cycles = 0;

  localparam logic [7:0] RST_EXP [10] = '{8'h00, 8'h66, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h0C, 8'h24};
  localparam logic [7:0] MSK_EXP [10] = '{8'h0F, 8'hFF, 8'h3F, 8'hFF,
    8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'h0F, 8'h3F};
  localparam logic [11:0] CODES [4] = '{12'h000, 12'h001, 12'h002, 12'hFFF};

  pll_frac_divider_config_regs dut_u (
    .pclk                     (pclk),
    .presetn                  (presetn),
    .psel                     (psel),
    .penable                  (penable),
    .pwrite                   (pwrite),
    .paddr                    (paddr),
    .pwdata                   (pwdata),
    .pstrb                    (pstrb),
    .prdata                   (prdata),
    .pready                   (pready),
    .pslverr                  (pslverr),
    .integer_feedback_divider (int_div),
    .divide_ratio             (ratio),
    .fraction_numerator       (num),
    .fraction_denominator     (den),
    .dither_select            (dither),
    .modulator_order          (order),
    .loop_resistor_code       (res_code)
  );

  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic results;
    if (bad_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Cuts a hung handshake short
  always @(posedge pclk) begin
    cycles++;
    // Full run needs about 300 cycles
    if (cycles == 2000) begin
      bad_count++;
      $display("BAD %0t timeout", $time);
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] e,
                     input string what);
    n_compared++;
    if (got !== e) begin
      bad_count++;
      $display("BAD %0t %s", $time, what);
    end
  endtask

  function automatic logic [11:0] ba(input byte_t idx);
    return {2'b00, idx, 2'b00};
  endfunction

  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Upper data bits set on purpose: they must never land anywhere
  task automatic wr(input byte_t idx, input logic [7:0] v);
    xfer(1'b1, ba(idx), {24'hA5A5A5, v}, 4'hF);
  endtask

  task automatic rd(input byte_t idx, input logic [7:0] e);
    xfer(1'b0, ba(idx), 32'h0, 4'h0);
    chk(rdat, {24'h0, e}, "read data");
    chk({31'h0, rerr}, 32'h0, "read error");
  endtask

  task automatic chk_cfg(input logic [11:0] d, input logic [21:0] n,
                         input logic [21:0] m, input logic [3:0] mc,
                         input logic [5:0] r);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk(32'(int_div), 32'(d), "divider");
    chk(32'(ratio), (d < 12'h002) ? 32'h1 : 32'(d), "ratio");
    chk(32'(num), 32'(n), "numerator");
    chk(32'(den), 32'(m), "denominator");
    chk(32'(dither), 32'(mc[3:2]), "dither");
    chk(32'(order), 32'(mc[1:0]), "order");
    chk(32'(res_code), 32'(r), "resistor");
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    chk_cfg(12'h066, 22'h0, 22'h0, 4'hC, 6'h24);
    for (int i = 0; i < 10; i++) begin
      rd(REG_INDEX[i], RST_EXP[i]);
    end
  endtask

  task automatic t_mask;
    for (int i = 0; i < 10; i++) begin
      wr(REG_INDEX[i], 8'hFF);
      rd(REG_INDEX[i], MSK_EXP[i]);
    end
    chk_cfg(12'hFFF, 22'h3FFFFF, 22'h3FFFFF, 4'hF, 6'h3F);
  endtask

  task automatic t_fields;
    wr(IDX_INT_DIVIDER_HIGH, 8'hFA);
    wr(IDX_INT_DIVIDER_LOW, 8'h5C);
    wr(IDX_FRAC_NUM_HIGH, 8'hD5);
    wr(IDX_FRAC_NUM_MID, 8'h9A);
    wr(IDX_FRAC_NUM_LOW, 8'h3C);
    wr(IDX_FRAC_DEN_HIGH, 8'hEB);
    wr(IDX_FRAC_DEN_MID, 8'h71);
    wr(IDX_FRAC_DEN_LOW, 8'hE4);
    wr(IDX_MODULATOR_CONTROL, 8'hF6);
    wr(IDX_LOOP_RESISTOR, 8'hC1);
    chk_cfg(12'hA5C, 22'h159A3C, 22'h2B71E4, 4'h6, 6'h01);
  endtask

  task automatic t_ratio;
    for (int i = 0; i < 4; i++) begin
      wr(IDX_INT_DIVIDER_HIGH, {4'h0, CODES[i][11:8]});
      wr(IDX_INT_DIVIDER_LOW, CODES[i][7:0]);
      chk_cfg(CODES[i], 22'h159A3C, 22'h2B71E4, 4'h6, 6'h01);
    end
  endtask

  task automatic t_modes;
    for (int i = 0; i < 16; i++) begin
      wr(IDX_MODULATOR_CONTROL, 8'(i));
      repeat (2) @(posedge pclk);
      chk(32'(dither), 32'(i[3:2]), "dither mode");
      chk(32'(order), 32'(i[1:0]), "order mode");
    end
  endtask

  task automatic t_refuse;
    xfer(1'b1, 12'h0E4, 32'hFF, 4'hF);
    chk({31'h0, rerr}, 32'h1, "unmapped error");
    xfer(1'b0, 12'h0E9, 32'h0, 4'h0);
    chk({31'h0, rerr} | rdat, 32'h1, "unaligned read");
    xfer(1'b1, ba(IDX_LOOP_RESISTOR), 32'h3, 4'hE);
    rd(IDX_LOOP_RESISTOR, 8'h01);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk_cfg(12'h066, 22'h0, 22'h0, 4'hC, 6'h24);
  endtask

  initial begin
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h000;
    pwdata     = 32'h0;
    pstrb      = 4'h0;
    bad_count  = 0;
    n_compared = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_mask();
    t_fields();
    t_ratio();
    t_modes();
    t_refuse();
    results();
  end
endmodule
